// *** bench/csactl_host.sv ***
// Host model that writes and reads the block's registers.
`timescale 1ns/1ps
`include "csactl_regs.svh"
module csactl_host (
  input wire logic core_clk,
  output logic reg_wr,
  output logic [`CSACTL_ADDR_W-1:0] reg_addr,
  output logic [`CSACTL_DATA_W-1:0] reg_wdata,
  input wire logic [`CSACTL_DATA_W-1:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 11'h000;
  end
  // Released write data is inverted so that a stale value is never taken.
  task automatic wr(input logic [3:0] a, input logic [10:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [10:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the sense amplifier control block.
`timescale 1ns/1ps
`include "csactl_regs.svh"
module tb;
  localparam int unsigned LONG = 20;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic reg_wr;
  logic [3:0] reg_addr;
  logic [10:0] reg_wdata;
  logic [10:0] reg_rdata;
  logic [10:0] rd_val;
  logic [1:0] sense_level = 2'b00;
  logic ds_level = 1'b0;
  logic gate_on_request = 1'b0;
  logic gate_is_on = 1'b0;
  logic in_sel, ref_half, ls_path, shunt_oc, ds_oc, gate_fault;
  logic [1:0] gain, thresh;
  logic [2:0] cal;
  logic [3:0] src_hs, snk_hs, src_ls, snk_ls;
  wire logic [10:0] fields = {in_sel, ref_half, ls_path, gain, 1'b0, cal, thresh};
  int n_errors = 0;
  int checks_done = 0;
  int n;
  csactl_top #(.RETRY_LONG_CYC(LONG)) csactl_top_i (.core_clk(core_clk), .reset_n(reset_n),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sense_level(sense_level), .ds_level(ds_level), .gate_on_request(gate_on_request),
    .gate_is_on(gate_is_on), .amp_input_select(in_sel), .amp_ref_half(ref_half),
    .low_side_measure_path(ls_path), .amp_gain_code(gain), .amp_offset_cal(cal),
    .sense_fault_threshold(thresh), .gate_source_current_hs(src_hs),
    .gate_sink_current_hs(snk_hs), .gate_source_current_ls(src_ls),
    .gate_sink_current_ls(snk_ls), .shunt_overcurrent(shunt_oc),
    .drain_source_overcurrent(ds_oc), .gate_drive_fault(gate_fault));
  csactl_host csactl_host_i (.core_clk(core_clk), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  initial forever #4 core_clk = ~core_clk;
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic t_field(input logic [10:0] d, input logic [10:0] exp);
    csactl_host_i.wr(4'h6, d);
    csactl_host_i.rd(4'h6, rd_val);
    check("sense reg", 16'(exp), 16'(rd_val));
    check("fields", 16'(exp & 11'h7df), 16'(fields));
  endtask
  task automatic t_regs;
    csactl_host_i.rd(4'h6, rd_val);
    check("reset value", 16'h0283, 16'(rd_val));
    check("reset fields", 16'h0283, 16'(fields));
    for (int i = 0; i < 4; i++) begin
      t_field({1'b0, i[0], i[1], i[1:0], 1'b0, ~i[2:0], i[1:0]},
              {1'b0, i[0], i[1], i[1:0], 1'b0, ~i[2:0], i[1:0]});
    end
    t_field(11'h400, 11'h500);
    t_field(11'h020, 11'h020);
    t_field(11'h000, 11'h000);
    csactl_host_i.wr(4'hf, 11'h7ff);
    csactl_host_i.rd(4'hf, rd_val);
    check("unmapped read", 16'h0000, 16'(rd_val));
    csactl_host_i.rd(4'h6, rd_val);
    check("sense reg kept", 16'h0000, 16'(rd_val));
    csactl_host_i.wr(4'h3, 11'h0a5);
    csactl_host_i.wr(4'h4, 11'h05a);
    @(negedge core_clk);
    check("drive codes", 16'ha55a, {src_hs, snk_hs, src_ls, snk_ls});
  endtask
  // One-cycle trip pulse, then the cycles with the fault high are counted.
  task automatic pulse_count(input logic ds, input int win, output int cnt);
    @(posedge core_clk);
    ds_level <= ds;
    sense_level <= ds ? 2'b00 : 2'b11;
    @(posedge core_clk);
    ds_level <= 1'b0;
    sense_level <= 2'b00;
    cnt = 0;
    repeat (win) begin
      @(negedge core_clk);
      if ((ds ? ds_oc : shunt_oc) === 1'b1) cnt++;
    end
  endtask
  task automatic t_retry;
    csactl_host_i.wr(4'h5, 11'h159);
    t_field(11'h281, 11'h281);
    // A fault left running from the earlier zero threshold must end before counting.
    repeat (LONG + 4) @(posedge core_clk);
    @(negedge core_clk);
    check("sense fault idle", 16'h0000, 16'(shunt_oc));
    pulse_count(1'b0, 60, n);
    check("sense fault long", 16'(LONG + 1), 16'(n));
    pulse_count(1'b1, 60, n);
    check("ds fault long", 16'(LONG + 1), 16'(n));
    csactl_host_i.wr(4'h5, 11'h559);
    pulse_count(1'b0, 6400, n);
    check("sense fault short", 16'(`CSACTL_RETRY_SHORT_CYC + 1), 16'(n));
    t_field(11'h2a1, 11'h2a1);
    pulse_count(1'b0, 60, n);
    check("disabled fault", 16'h0000, 16'(n));
  endtask
  task automatic t_gate;
    @(posedge core_clk);
    gate_on_request <= 1'b1;
    gate_is_on <= 1'b1;
    repeat (600) @(posedge core_clk);
    gate_is_on <= 1'b0;
    repeat (`CSACTL_DRIVE_WINDOW_CYC - 1) @(posedge core_clk);
    @(negedge core_clk);
    check("gate fault early", 16'h0000, 16'(gate_fault));
    @(negedge core_clk);
    check("gate fault set", 16'h0001, 16'(gate_fault));
    @(posedge core_clk);
    gate_on_request <= 1'b0;
    csactl_host_i.wr(4'h5, 11'h159);
    @(negedge core_clk);
    check("gate fault cleared", 16'h0000, 16'(gate_fault));
  endtask
  initial begin
    repeat (30000) @(posedge core_clk);
    n_errors++;
    wrap_up;
  end
  initial begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    t_regs;
    t_retry;
    t_gate;
    wrap_up;
  end
endmodule

// *** src/csactl_pkg.sv ***
// Types shared by the sense amplifier control block.
package csactl_pkg;
  typedef enum logic [2:0] {
    CSACTL_RUN = 3'b001,
    CSACTL_TRIP = 3'b010,
    CSACTL_WAIT = 3'b100
  } csactl_fault_st_t;
endpackage

// *** src/csactl_regs.svh ***
// Register offsets, field positions, reset values and timing counts for the sense amplifier block.
`ifndef CSACTL_REGS_SVH
`define CSACTL_REGS_SVH
`define CSACTL_ADDR_W 4
`define CSACTL_DATA_W 11
`define CSACTL_OFF_DRV_HS 4'h3
`define CSACTL_OFF_DRV_LS 4'h4
`define CSACTL_OFF_OCP 4'h5
`define CSACTL_OFF_SENSE_AMP 4'h6
`define CSACTL_BIT_INPUT_SEL 10
`define CSACTL_BIT_REF_HALF 9
`define CSACTL_BIT_LS_PATH 8
`define CSACTL_GAIN_HI 7
`define CSACTL_GAIN_LO 6
`define CSACTL_BIT_SENSE_DIS 5
`define CSACTL_BIT_CAL_A 4
`define CSACTL_BIT_CAL_B 3
`define CSACTL_BIT_CAL_C 2
`define CSACTL_LVL_HI 1
`define CSACTL_LVL_LO 0
`define CSACTL_BIT_RETRY_SEL 10
`define CSACTL_RST_SENSE_AMP 11'h283
`define CSACTL_RST_DRV 11'h3ff
`define CSACTL_RST_OCP 11'h159
`define CSACTL_CLK_NS 8
`define CSACTL_RETRY_LONG_US 4000
`define CSACTL_RETRY_SHORT_US 50
`define CSACTL_RETRY_LONG_CYC ((`CSACTL_RETRY_LONG_US * 1000) / `CSACTL_CLK_NS)
`define CSACTL_RETRY_SHORT_CYC ((`CSACTL_RETRY_SHORT_US * 1000) / `CSACTL_CLK_NS)
`define CSACTL_DRIVE_WINDOW_NS 4000
`define CSACTL_DRIVE_WINDOW_CYC (`CSACTL_DRIVE_WINDOW_NS / `CSACTL_CLK_NS)
`endif

// *** src/csactl_retry.sv ***
// Fault latch with retry timer used for both overcurrent sources.
`timescale 1ns/1ps
`include "csactl_regs.svh"
module csactl_retry #(
  parameter int unsigned LONG_CYC = `CSACTL_RETRY_LONG_CYC,
  parameter int unsigned SHORT_CYC = `CSACTL_RETRY_SHORT_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic trip,
  input wire logic short_sel,
  output logic fault
);
  csactl_pkg::csactl_fault_st_t st_q, st_d;
  logic [19:0] cnt_q, cnt_d;
  wire [19:0] load_val = short_sel ? 20'(SHORT_CYC - 1) : 20'(LONG_CYC - 1);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    unique case (st_q)
      csactl_pkg::CSACTL_RUN: begin
        if (trip) begin
          st_d = csactl_pkg::CSACTL_TRIP;
        end
      end
      csactl_pkg::CSACTL_TRIP: begin
        st_d = csactl_pkg::CSACTL_WAIT;
        cnt_d = load_val;
      end
      csactl_pkg::CSACTL_WAIT: begin
        if (cnt_q == 20'h00000) begin
          st_d = csactl_pkg::CSACTL_RUN;
        end else begin
          cnt_d = cnt_q - 20'h00001;
        end
      end
      default: st_d = csactl_pkg::CSACTL_RUN;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= csactl_pkg::CSACTL_RUN;
      cnt_q <= 20'h00000;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  assign fault = (st_q != csactl_pkg::CSACTL_RUN);
endmodule

// *** src/csactl_top.sv ***
// Sense amplifier control register, drive strength registers and overcurrent fault handling.
`timescale 1ns/1ps
`include "csactl_regs.svh"
// Notes on behaviour
// - Sense amplifier control register sits at address 0x06, fully readable and writable.
// - Register exists only when the amplifier variant is built in.
// - Bit 10 picks amplifier positive input: shunt pin or phase node, reset 0.
// - Writing bit 10 as one also forces bit 8 to one.
// - Bit 9 picks full or halved reference, reset 1.
// - Bit 8 picks low-side overcurrent path to shunt positive or negative, reset 0.
// - Bits 7-6 pick gain 5, 10, 20 or 40, reset 10b.
// - Bit 5 high disables sense overcurrent detection and action, reset 0.
// - Bits 4, 3, 2 short amplifiers A, B, C for offset calibration.
// - Bits 1-0 pick sense overcurrent threshold, reset 11b.
// - Gate not fully on within the drive window may raise a gate fault.
// - Source and sink strengths for each side set independently by register.
// - Overcurrent retry delay is 4 ms or 50 us by one select bit.
module csactl_top #(
  parameter bit HAS_AMPS = 1'b1,
  parameter int unsigned RETRY_LONG_CYC = `CSACTL_RETRY_LONG_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic [`CSACTL_ADDR_W-1:0] reg_addr,
  input wire logic [`CSACTL_DATA_W-1:0] reg_wdata,
  output logic [`CSACTL_DATA_W-1:0] reg_rdata,
  input wire logic [1:0] sense_level,
  input wire logic ds_level,
  input wire logic gate_on_request,
  input wire logic gate_is_on,
  output logic amp_input_select,
  output logic amp_ref_half,
  output logic low_side_measure_path,
  output logic [1:0] amp_gain_code,
  output logic [2:0] amp_offset_cal,
  output logic [1:0] sense_fault_threshold,
  output logic [3:0] gate_source_current_hs,
  output logic [3:0] gate_sink_current_hs,
  output logic [3:0] gate_source_current_ls,
  output logic [3:0] gate_sink_current_ls,
  output logic shunt_overcurrent,
  output logic drain_source_overcurrent,
  output logic gate_drive_fault
);
  logic [10:0] amp_q, drv_hs_q, drv_ls_q, ocp_q;
  logic [10:0] amp_d;
  logic [9:0] win_cnt_q;
  logic gdf_q;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  wire wr_amp = reg_wr && hit(reg_addr, `CSACTL_OFF_SENSE_AMP) && HAS_AMPS;
  wire wr_hs = reg_wr && hit(reg_addr, `CSACTL_OFF_DRV_HS);
  wire wr_ls = reg_wr && hit(reg_addr, `CSACTL_OFF_DRV_LS);
  wire wr_ocp = reg_wr && hit(reg_addr, `CSACTL_OFF_OCP);

  // Choosing the phase node as input also moves the low-side path to the negative pin.
  always_comb begin
    amp_d = amp_q;
    if (wr_amp) begin
      amp_d = reg_wdata;
      if (reg_wdata[`CSACTL_BIT_INPUT_SEL]) begin
        amp_d[`CSACTL_BIT_LS_PATH] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      amp_q <= `CSACTL_RST_SENSE_AMP;
      drv_hs_q <= `CSACTL_RST_DRV;
      drv_ls_q <= `CSACTL_RST_DRV;
      ocp_q <= `CSACTL_RST_OCP;
    end else begin
      amp_q <= amp_d;
      if (wr_hs) begin
        drv_hs_q <= {3'h0, reg_wdata[7:0]};
      end
      if (wr_ls) begin
        drv_ls_q <= {3'h0, reg_wdata[7:0]};
      end
      if (wr_ocp) begin
        ocp_q <= reg_wdata;
      end
    end
  end

  always_comb begin
    reg_rdata = 11'h000;
    if (hit(reg_addr, `CSACTL_OFF_SENSE_AMP) && HAS_AMPS) begin
      reg_rdata = amp_q;
    end else if (hit(reg_addr, `CSACTL_OFF_DRV_HS)) begin
      reg_rdata = drv_hs_q;
    end else if (hit(reg_addr, `CSACTL_OFF_DRV_LS)) begin
      reg_rdata = drv_ls_q;
    end else if (hit(reg_addr, `CSACTL_OFF_OCP)) begin
      reg_rdata = ocp_q;
    end
  end

  assign amp_input_select = amp_q[`CSACTL_BIT_INPUT_SEL];
  assign amp_ref_half = amp_q[`CSACTL_BIT_REF_HALF];
  assign low_side_measure_path = amp_q[`CSACTL_BIT_LS_PATH];
  assign amp_gain_code = amp_q[`CSACTL_GAIN_HI:`CSACTL_GAIN_LO];
  assign amp_offset_cal = amp_q[`CSACTL_BIT_CAL_A:`CSACTL_BIT_CAL_C];
  assign sense_fault_threshold = amp_q[`CSACTL_LVL_HI:`CSACTL_LVL_LO];
  assign gate_source_current_hs = drv_hs_q[7:4];
  assign gate_sink_current_hs = drv_hs_q[3:0];
  assign gate_source_current_ls = drv_ls_q[7:4];
  assign gate_sink_current_ls = drv_ls_q[3:0];

  wire sense_trip = HAS_AMPS && !amp_q[`CSACTL_BIT_SENSE_DIS] &&
    (sense_level >= amp_q[`CSACTL_LVL_HI:`CSACTL_LVL_LO]);
  wire retry_short = ocp_q[`CSACTL_BIT_RETRY_SEL];

  csactl_retry #(.LONG_CYC(RETRY_LONG_CYC)) u_sense_retry (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .trip(sense_trip),
    .short_sel(retry_short),
    .fault(shunt_overcurrent)
  );

  csactl_retry #(.LONG_CYC(RETRY_LONG_CYC)) u_ds_retry (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .trip(ds_level),
    .short_sel(retry_short),
    .fault(drain_source_overcurrent)
  );

  // Gate must reach full enhancement before the window counter runs out.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      win_cnt_q <= 10'h000;
      gdf_q <= 1'b0;
    end else begin
      if (!gate_on_request || gate_is_on) begin
        win_cnt_q <= 10'h000;
      end else if (win_cnt_q != 10'(`CSACTL_DRIVE_WINDOW_CYC)) begin
        win_cnt_q <= win_cnt_q + 10'h001;
      end
      if (gate_on_request && !gate_is_on &&
          win_cnt_q == 10'(`CSACTL_DRIVE_WINDOW_CYC - 1)) begin
        gdf_q <= 1'b1;
      end else if (wr_ocp) begin
        gdf_q <= 1'b0;
      end
    end
  end
  assign gate_drive_fault = gdf_q;

  chk_reset_value: assert property (@(posedge core_clk) $rose(reset_n) |-> amp_q == 11'h283)
    else $error("sense register reset value wrong");
  chk_input_forces_path: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_amp && reg_wdata[10] |=> low_side_measure_path && amp_input_select)
    else $error("input select did not force low side path");
  chk_write_lands: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_amp && !reg_wdata[10] |=> amp_q == $past(reg_wdata))
    else $error("sense register write lost");
  chk_gain_follows: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_amp |=> amp_gain_code == $past(reg_wdata[7:6]))
    else $error("gain code mismatch");
  chk_cal_follows: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_amp |=> amp_offset_cal == $past(reg_wdata[4:2]))
    else $error("offset cal mismatch");
  chk_sense_disabled: assert property (@(posedge core_clk) disable iff (!reset_n)
    amp_q[`CSACTL_BIT_SENSE_DIS] && !shunt_overcurrent |=> !shunt_overcurrent)
    else $error("sense fault while disabled");
  chk_sense_trips: assert property (@(posedge core_clk) disable iff (!reset_n)
    sense_trip && !shunt_overcurrent |=> shunt_overcurrent)
    else $error("sense trip not latched");
  chk_short_retry: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(shunt_overcurrent) && retry_short |-> ##1 shunt_overcurrent [*8])
    else $error("retry ended early");
  chk_gate_window: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(gate_drive_fault) |-> $past(gate_on_request) && !$past(gate_is_on))
    else $error("gate fault without cause");
  chk_ref_follows: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_amp |=> amp_ref_half == $past(reg_wdata[9]))
    else $error("reference select mismatch");
  chk_input_follows: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_amp |=> amp_input_select == $past(reg_wdata[10]))
    else $error("input select mismatch");
  chk_path_follows: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_amp |=> low_side_measure_path == ($past(reg_wdata[8]) || $past(reg_wdata[10])))
    else $error("low side path mismatch");
  chk_level_follows: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_amp |=> sense_fault_threshold == $past(reg_wdata[1:0]))
    else $error("threshold mismatch");
  chk_reg_holds: assert property (@(posedge core_clk) disable iff (!reset_n)
    !wr_amp |=> $stable(amp_q))
    else $error("sense register changed without write");
  chk_amp_readback: assert property (@(posedge core_clk) disable iff (!reset_n)
    HAS_AMPS && hit(reg_addr, `CSACTL_OFF_SENSE_AMP) |-> reg_rdata == amp_q)
    else $error("sense register read mismatch");
  chk_hs_drive: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_hs |=> gate_source_current_hs == $past(reg_wdata[7:4]) &&
      gate_sink_current_hs == $past(reg_wdata[3:0]))
    else $error("high side drive code mismatch");
  chk_ls_drive: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_ls |=> gate_source_current_ls == $past(reg_wdata[7:4]) &&
      gate_sink_current_ls == $past(reg_wdata[3:0]))
    else $error("low side drive code mismatch");
  chk_below_level: assert property (@(posedge core_clk) disable iff (!reset_n)
    !shunt_overcurrent && sense_level < sense_fault_threshold |=> !shunt_overcurrent)
    else $error("sense fault below threshold");
  chk_ds_trips: assert property (@(posedge core_clk) disable iff (!reset_n)
    ds_level && !drain_source_overcurrent |=> drain_source_overcurrent)
    else $error("drain source trip not latched");
  chk_ds_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
    !ds_level && !drain_source_overcurrent |=> !drain_source_overcurrent)
    else $error("drain source fault without trip");
  chk_long_retry: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(shunt_overcurrent) && !retry_short |-> ##1 shunt_overcurrent [*8])
    else $error("long retry ended early");
  chk_gate_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
    gate_drive_fault && !wr_ocp |=> gate_drive_fault)
    else $error("gate fault dropped without clear");
  chk_gate_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_ocp && !gate_on_request |=> !gate_drive_fault)
    else $error("gate fault not cleared");
endmodule
